// ==== ssso_pkg.sv ====
// Purpose: shared constants and types for the serial port status and state observer
// Assumes: 32-bit avalon-mm register bus, byte addressing, one register per word
// Notes:   register word index times four gives the byte address
package ssso_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;

  // register word indices
  localparam logic [IDX_W-1:0] IDX_DATA     = 14'h0f60;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 14'h0f61;
  localparam logic [IDX_W-1:0] IDX_MODE     = 14'h0f63;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 14'h0f64;
  localparam logic [IDX_W-1:0] IDX_MONITOR  = 14'h0f65;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 14'h0f68;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 14'h0f69;

  // status bit positions (interrupt status and mask share this layout)
  localparam int ST_TX_EMPTY  = 7;
  localparam int ST_UNDERRUN  = 6;
  localparam int ST_COLLISION = 5;
  localparam int ST_ABORT     = 4;
  localparam int ST_OVERRUN   = 3;
  localparam int ST_RX_FULL   = 2;
  localparam int ST_ACTIVE    = 1;
  localparam int ST_SELECT    = 0;

  // control and mode fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_RATE   = 2;
  localparam int MODE_NB_LO  = 2;
  localparam int MODE_NB_HI  = 4;

  localparam logic [7:0] STATUS_RESET  = 8'h81;
  localparam logic [7:0] MONITOR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] BYTE_ONES     = 8'hff;

  // engine state codes seen by software
  localparam logic [5:0] CODE_IDLE   = 6'h00;
  localparam logic [5:0] CODE_SWAIT  = 6'h01;
  localparam logic [5:0] CODE_MREADY = 6'h11;
  localparam logic [1:0] CODE_BIT    = 2'h2;

  localparam logic [3:0] FULL_CHAR = 4'h8;
  localparam logic [3:0] ONE_BIT   = 4'h1;

  localparam int TIMER_W         = 16;
  localparam int HALF_CYCLES_DEF = 4;
  localparam int MON_TIMEOUT_DEF = 1024;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SWAIT  = 5'h02,
    ST_MREADY = 5'h04,
    ST_BRX    = 5'h08,
    ST_BTX    = 5'h10
  } ssso_state_type;

  typedef struct packed {
    logic                 enable;
    logic                 master;
    logic                 rate_mon;
    logic [2:0]           char_bit_count;
    logic [7:0]           tx_hold;
    logic                 tx_holding_empty;
    logic [7:0]           rx_hold;
    logic                 rx_holding_full;
    logic                 tx_underrun_flag;
    logic                 collision_flag;
    logic                 slave_abort_flag;
    logic                 rx_overrun_flag;
    logic [7:0]           shift;
    logic                 sample;
    logic                 loaded;
    ssso_state_type       state;
    logic [2:0]           idx;
    logic [TIMER_W-1:0]   timer;
    logic                 sck_prev;
    logic                 sel_prev;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_mask;
    logic                 irq;
    logic                 wait_req;
    logic [DATA_W-1:0]    rdata;
    logic                 sck_out;
    logic                 sck_oe;
    logic                 mosi_out;
    logic                 mosi_oe;
    logic                 miso_out;
    logic                 miso_oe;
  } ssso_regs_type;

endpackage

// ==== ssso_pin_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for link pins
// Assumes: inputs are asynchronous to clock
// Notes:   a change counts only when stages two and three agree
`timescale 1ns/1ps
module ssso_pin_sync #(
  parameter int    W         = 4,
  parameter logic  RESET_VAL = 1'b0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ssso_sync_type;

  ssso_sync_type q;
  ssso_sync_type d;

  ////////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second stage
  always_comb begin
    d     = q;
    d.s1  = pin_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= {4 * W{RESET_VAL}};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule

// ==== ssso_observer.sv ====
// Purpose: status flags, pin monitor and state code of the serial port, with a
//          small shift engine that produces the events the flags observe
// Assumes: avalon-mm slave with waitrequest; link pins sampled by clock
// Notes:   serial mode 0 only (sample on rising, shift on falling), msb first
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module ssso_observer
  import ssso_pkg::*;
#(
  parameter int HALF_CYCLES = ssso_pkg::HALF_CYCLES_DEF,
  parameter int MON_TIMEOUT = ssso_pkg::MON_TIMEOUT_DEF
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic [ssso_pkg::ADDR_W-1:0]   address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [ssso_pkg::DATA_W-1:0]   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [ssso_pkg::DATA_W-1:0]   readdata,
  output logic                               waitrequest,
  output logic                               irq,
  input  wire logic                          sck_in,
  input  wire logic                          select_n_in,
  input  wire logic                          mosi_in,
  input  wire logic                          miso_in,
  output logic                               sck_out,
  output logic                               sck_oe,
  output logic                               mosi_out,
  output logic                               mosi_oe,
  output logic                               miso_out,
  output logic                               miso_oe
);
  import ssso_pkg::*;

  if (HALF_CYCLES < 1 || HALF_CYCLES >= (1 << TIMER_W)) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end
  if (MON_TIMEOUT < 2 || MON_TIMEOUT >= (1 << TIMER_W)) begin : g_bad_mon
    $error("MON_TIMEOUT out of range");
  end

  localparam logic [TIMER_W-1:0] HALF_LAST = TIMER_W'(HALF_CYCLES - 1);
  localparam logic [TIMER_W-1:0] MON_LAST  = TIMER_W'(MON_TIMEOUT - 1);
  localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;

  localparam ssso_regs_type REGS_RESET = '{
    enable: 1'b0, master: 1'b0, rate_mon: 1'b0, char_bit_count: 3'h0,
    tx_hold: 8'h00, tx_holding_empty: STATUS_RESET[ST_TX_EMPTY],
    rx_hold: 8'h00, rx_holding_full: 1'b0, tx_underrun_flag: 1'b0,
    collision_flag: 1'b0, slave_abort_flag: 1'b0, rx_overrun_flag: 1'b0,
    shift: 8'h00, sample: 1'b0, loaded: 1'b0, state: ST_IDLE, idx: 3'h0,
    timer: '0, sck_prev: 1'b0, sel_prev: 1'b0, irq_stat: 8'h00,
    irq_mask: 8'h00, irq: 1'b0, wait_req: 1'b1, rdata: '0,
    sck_out: 1'b0, sck_oe: 1'b0, mosi_out: 1'b0, mosi_oe: 1'b0,
    miso_out: 1'b0, miso_oe: 1'b0
  };

  ssso_regs_type q;
  ssso_regs_type d;
  logic [3:0]    pins_f;
  logic          sck_f;
  logic          sel_f;
  logic          mosi_f;
  logic          miso_f;

  ////////////////////////////////////////////////////////////////////////////
  // link pins; select is inverted first, so the filter's low reset reads as deselected
  ssso_pin_sync #(
    .W         (4),
    .RESET_VAL (1'b0)
  ) u_sync (
    .clock  (clock),
    .rst    (rst),
    .pin_in ({sck_in, ~select_n_in, mosi_in, miso_in}),
    .level  (pins_f)
  );

  assign sck_f  = pins_f[3];
  assign sel_f  = pins_f[2];
  assign mosi_f = pins_f[1];
  assign miso_f = pins_f[0];

  ////////////////////////////////////////////////////////////////////////////
  // state code: bit states carry the index and a receive/transmit phase
  function automatic logic [5:0] state_code(input ssso_state_type st,
                                            input logic [2:0] idx);
    logic [5:0] c;
    c = CODE_IDLE;
    case (st)
      ST_SWAIT:  c = CODE_SWAIT;
      ST_MREADY: c = CODE_MREADY;
      ST_BRX:    c = {CODE_BIT, idx, 1'b0};
      ST_BTX:    c = {CODE_BIT, idx, 1'b1};
      default:   c = CODE_IDLE;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic              req;
    logic              cap;
    logic              wr;
    logic [IDX_W-1:0]  widx;
    logic [7:0]        wb;
    logic [7:0]        ev;
    logic [7:0]        stat;
    logic [7:0]        clr;
    logic              din;
    logic [3:0]        nbits;
    logic [3:0]        nm1;
    logic [3:0]        sh_amt;
    logic [7:0]        rx_word;
    logic              rise;
    logic              fall;
    logic              in_bits;
    logic [2:0]        cur_idx;
    logic              load;

    d       = q;
    req     = read | write;
    cap     = req & q.wait_req;
    wr      = write & ~q.wait_req & byteenable[0];
    widx    = address[ADDR_W-1:2];
    wb      = writedata[7:0];
    ev      = BYTE_ZERO;
    clr     = BYTE_ZERO;
    din     = q.master ? miso_f : mosi_f;
    nbits   = (q.char_bit_count == 3'h0) ? FULL_CHAR
                                          : {1'b0, q.char_bit_count};
    nm1     = nbits - ONE_BIT;
    sh_amt  = FULL_CHAR - nbits;
    rx_word = {q.shift[6:0], din} & (BYTE_ONES >> sh_amt);
    rise    = 1'b0;
    fall    = 1'b0;
    in_bits = (q.state == ST_BRX) || (q.state == ST_BTX);
    cur_idx = (q.state == ST_BRX || q.state == ST_BTX) ? q.idx : nm1[2:0];
    load    = 1'b0;

    // status view; disabled port shows reset value of every flag
    stat = STATUS_RESET;
    if (q.enable) begin
      stat[ST_TX_EMPTY]  = q.tx_holding_empty;
      stat[ST_UNDERRUN]  = q.tx_underrun_flag;
      stat[ST_COLLISION] = q.collision_flag;
      stat[ST_ABORT]     = q.slave_abort_flag;
      stat[ST_OVERRUN]   = q.rx_overrun_flag;
      stat[ST_RX_FULL]   = q.rx_holding_full;
      stat[ST_ACTIVE]    = in_bits || (q.state == ST_MREADY);
      stat[ST_SELECT]    = ~sel_f;
    end

    //////////////////////////////////////////////////////////////////////////
    // bus: read data captured when waitrequest drops, write acts one edge later, as waitrequest rises again
    d.wait_req = ~cap;
    if (cap && read) begin
      d.rdata = '0;
      case (widx)
        IDX_STATUS:   d.rdata[7:0] = stat;
        IDX_MONITOR:  d.rdata[7:0] = q.enable ? {sck_f, din, state_code(q.state, q.idx)}
                                              : MONITOR_RESET;
        IDX_CTRL:     d.rdata[2:0] = {q.rate_mon, q.master, q.enable};
        IDX_MODE:     d.rdata[MODE_NB_HI:MODE_NB_LO] = q.char_bit_count;
        IDX_DATA:     d.rdata[7:0] = q.rx_hold;
        IDX_IRQ_STAT: d.rdata[7:0] = q.irq_stat;
        IDX_IRQ_MASK: d.rdata[7:0] = q.irq_mask;
        default:      d.rdata = '0;
      endcase
      if (widx == IDX_DATA) begin
        d.rx_holding_full = 1'b0;
      end
      if (widx == IDX_IRQ_STAT) begin
        clr = BYTE_ONES;
      end
    end

    if (wr) begin
      case (widx)
        IDX_CTRL: begin
          d.enable   = wb[CTRL_ENABLE];
          d.master   = wb[CTRL_MASTER];
          d.rate_mon = wb[CTRL_RATE];
        end
        IDX_MODE:     d.char_bit_count = wb[MODE_NB_HI:MODE_NB_LO];
        IDX_IRQ_MASK: d.irq_mask = wb;
        IDX_STATUS: begin
          // only ones clear; read-only bits ignore the write
          d.tx_underrun_flag = q.tx_underrun_flag & ~wb[ST_UNDERRUN];
          d.collision_flag   = q.collision_flag & ~wb[ST_COLLISION];
          d.slave_abort_flag = q.slave_abort_flag & ~wb[ST_ABORT];
          d.rx_overrun_flag  = q.rx_overrun_flag & ~wb[ST_OVERRUN];
        end
        default: d.enable = q.enable;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // engine; flag sets come after the clears so a same-cycle event survives
    d.sck_prev = sck_f;
    d.sel_prev = sel_f;
    if (sel_f != q.sel_prev) begin
      ev[ST_SELECT] = 1'b1;
    end

    if (q.master) begin
      if ((q.state == ST_MREADY || q.state == ST_BRX) && q.timer == HALF_LAST) begin
        rise = 1'b1;
      end
      if (q.state == ST_BTX && q.timer == HALF_LAST) begin
        fall = 1'b1;
      end
    end else begin
      rise = sck_f & ~q.sck_prev;
      fall = ~sck_f & q.sck_prev;
    end

    d.timer = (in_bits || q.state == ST_MREADY) ? q.timer + TIMER_ONE : TIMER_ZERO;

    case (q.state)
      ST_IDLE: begin
        if (q.master && !q.tx_holding_empty) begin
          load    = 1'b1;
          d.state = ST_MREADY;
        end else if (!q.master && sel_f) begin
          d.state  = ST_SWAIT;
          d.loaded = 1'b0;
        end
      end
      ST_SWAIT: begin
        if (!sel_f) begin
          d.state = ST_IDLE;
        end else if (!q.loaded && !q.tx_holding_empty && !rise) begin
          load = 1'b1;
        end
      end
      default: d.state = q.state;
    endcase

    if (rise && (q.state == ST_SWAIT || q.state == ST_MREADY || q.state == ST_BRX)) begin
      d.sample = din;
      d.idx    = cur_idx;
      d.state  = ST_BTX;
      d.timer  = TIMER_ZERO;
      if (q.state == ST_SWAIT && !q.loaded) begin
        d.tx_underrun_flag = 1'b1;
        ev[ST_UNDERRUN]    = 1'b1;
        // nothing to send: zeros go out instead of stale shift contents
        d.shift            = BYTE_ZERO;
      end
      if (cur_idx == 3'h0) begin
        ev[ST_ACTIVE] = 1'b1;
        if (q.rx_holding_full && !(cap && read && widx == IDX_DATA)) begin
          // overrun keeps the unread character
          d.rx_overrun_flag = 1'b1;
          ev[ST_OVERRUN]    = 1'b1;
        end else begin
          d.rx_hold         = rx_word;
          d.rx_holding_full = 1'b1;
          ev[ST_RX_FULL]    = 1'b1;
        end
        if (!q.master) begin
          d.state  = ST_SWAIT;
          d.loaded = 1'b0;
        end
      end
    end

    if (fall && q.state == ST_BTX) begin
      d.timer = TIMER_ZERO;
      if (q.idx == 3'h0) begin
        d.state = ST_IDLE;
        if (!q.tx_holding_empty) begin
          load    = 1'b1;
          d.state = ST_MREADY;
        end
      end else begin
        d.shift = {q.shift[6:0], q.sample};
        d.idx   = q.idx - 3'h1;
        d.state = ST_BRX;
      end
    end

    if (load) begin
      d.shift            = q.tx_hold << sh_amt;
      d.tx_holding_empty = 1'b1;
      d.loaded           = 1'b1;
      ev[ST_TX_EMPTY]    = 1'b1;
    end

    // another master pulling select low while we drive is a mode fault
    if (q.master && sel_f) begin
      d.collision_flag = 1'b1;
      ev[ST_COLLISION] = 1'b1;
      d.state          = ST_IDLE;
    end

    if (!q.master && in_bits) begin
      if (!sel_f) begin
        d.slave_abort_flag = 1'b1;
        ev[ST_ABORT]       = 1'b1;
        d.state            = ST_IDLE;
      end else if (q.rate_mon && q.timer == MON_LAST && !rise && !fall) begin
        d.slave_abort_flag = 1'b1;
        ev[ST_ABORT]       = 1'b1;
        d.state            = ST_IDLE;
      end
    end

    if (wr && widx == IDX_DATA) begin
      d.tx_hold          = wb;
      d.tx_holding_empty = 1'b0;
    end

    // disabled port: engine and every flag back to reset
    if (!q.enable) begin
      d.tx_holding_empty = REGS_RESET.tx_holding_empty;
      d.rx_holding_full  = 1'b0;
      d.tx_underrun_flag = 1'b0;
      d.collision_flag   = 1'b0;
      d.slave_abort_flag = 1'b0;
      d.rx_overrun_flag  = 1'b0;
      d.state            = ST_IDLE;
      d.loaded           = 1'b0;
      d.idx              = 3'h0;
      d.timer            = TIMER_ZERO;
      ev                 = BYTE_ZERO;
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt: sticky events, cleared by a read, set wins over that clear
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);

    // pins: master drives clock and mosi, slave drives miso while selected
    d.sck_out  = d.master && (d.state == ST_BTX);
    d.sck_oe   = d.enable && d.master;
    d.mosi_out = d.shift[7];
    d.mosi_oe  = d.enable && d.master;
    d.miso_out = d.shift[7];
    d.miso_oe  = d.enable && !d.master && sel_f;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= REGS_RESET;
    end else begin
      q <= d;
    end
  end

  assign readdata    = q.rdata;
  assign waitrequest = q.wait_req;
  assign irq         = q.irq;
  assign sck_out     = q.sck_out;
  assign sck_oe      = q.sck_oe;
  assign mosi_out    = q.mosi_out;
  assign mosi_oe     = q.mosi_oe;
  assign miso_out    = q.miso_out;
  assign miso_oe     = q.miso_oe;

endmodule

// ==== ssso_observer_monitor.sv ====
// Purpose: port checker for the status and state observer
// Assumes: one clock domain; sim values of the counts handed on by bind
// Notes:   sees only the observer's ports
`timescale 1ns/1ps
module ssso_observer_monitor
  import ssso_pkg::*;
#(
  parameter int HALF_CYCLES = 4,
  parameter int MON_TIMEOUT = 1024
) (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic [ssso_pkg::ADDR_W-1:0] address,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [ssso_pkg::DATA_W-1:0] readdata,
  input wire logic                        waitrequest,
  input wire logic                        irq,
  input wire logic                        select_n_in,
  input wire logic                        sck_out,
  input wire logic                        sck_oe,
  input wire logic                        mosi_oe,
  input wire logic                        miso_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_rdata_hold: assert property (!read |=> $stable(readdata))
    else $error("read data changed without a read");
  a_reset_quiet: assert property ($fell(rst) |-> waitrequest && !irq && !sck_oe && !miso_oe)
    else $error("outputs not quiet after reset");
  a_master_pins: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master drives wrong pins");
  a_mosi_clock: assert property (mosi_oe |-> sck_oe)
    else $error("data out driven without clock");
  a_slave_sel: assert property (select_n_in [*8] |=> !miso_oe)
    else $error("slave output driven while not selected");
  // a half period of the master clock spans at least two cycles once HALF_CYCLES exceeds one
  a_sck_half: assert property ((HALF_CYCLES > 1) && sck_oe && $changed(sck_out)
    |=> $stable(sck_out))
    else $error("master clock half period too short");
  ////////////////////////////////////////////////////////////////////////////////
  c_status_read: cover property (read && !waitrequest && address[15:2] == IDX_STATUS);
  c_slave_drive: cover property ($rose(miso_oe));
  c_master_clock: cover property (sck_oe && $rose(sck_out));
  c_irq_raised: cover property ($rose(irq));
endmodule
bind ssso_observer ssso_observer_monitor #(
  .HALF_CYCLES(HALF_CYCLES),
  .MON_TIMEOUT(MON_TIMEOUT)
) mon_u (
  .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .select_n_in(select_n_in),
  .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe)
);

// ==== ssso_spi_master_model.sv ====
// Purpose: external spi master on the far side of the observer's link
// Assumes: mode 0, msb first, 64 ns link clock
// Notes:   clock stands low outside frames; released mosi shows the inverse value
`timescale 1ns/1ps
module ssso_spi_master_model (
  output logic      sck,
  output logic      select_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck      = 1'b0;
    select_n = 1'b1;
    mosi     = 1'b0;
  end
  task automatic sel(input logic v, input logic d);
    select_n = v;
    mosi     = d;
  endtask
  // miso is taken just before each rise, a full half period after the shift
  task automatic frame(input logic [7:0] tx, input int n, input bit keep,
                       output logic [7:0] rx);
    rx = 8'h00;
    sel(1'b0, tx[n-1]);
    #97;
    for (int i = n - 1; i >= 0; i--) begin
      rx  = {rx[6:0], miso};
      sck = 1'b1;
      #32;
      sck = 1'b0;
      if (i > 0) mosi = tx[i-1];
      #32;
    end
    if (!keep) begin
      sel(1'b1, ~tx[0]);
      #64;
    end
  endtask
endmodule

// ==== test_spi_status_state_observer.sv ====
// Purpose: self-checking bench for the status and state observer
// Assumes: 200 MHz clock; link driven by the master model
// Notes:   short master half period and clock-monitor timeout
`timescale 1ns/1ps
module test_spi_status_state_observer;
  import ssso_pkg::*;
  logic              clock, rst, read, write, waitrequest, irq;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata;
  logic              sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic              m_sck, m_sel_n, m_mosi;
  logic [7:0]        rx, rd;
  int                err_count, checks;
  wire               sck_w  = sck_oe ? sck_out : m_sck;
  wire               mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire               miso_w = miso_oe ? miso_out : 1'b1;
  ssso_observer #(.HALF_CYCLES(2), .MON_TIMEOUT(16)) dut_u (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .sck_in(sck_w), .select_n_in(m_sel_n),
    .mosi_in(mosi_w), .miso_in(miso_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe));
  ssso_spi_master_model m_u (.sck(m_sck), .select_n(m_sel_n), .mosi(m_mosi), .miso(miso_w));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // waitrequest and read data are taken at the rising edge, before the design updates
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clock);
    address   <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    read      <= ~wr;
    write     <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    r = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("[ERR] %0t bus timeout", $time);
      end_sim();
    end
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask
  task automatic rc(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    chk(rd, exp);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(IDX_STATUS, 8'h81);
    rc(IDX_MONITOR, 8'h00);
    rc(14'h0f70, 8'h00);
  endtask
  task automatic t_slave;
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_DATA, 8'ha5);
    rc(IDX_STATUS, 8'h01);
    m_u.sel(1'b0, 1'b1);
    w(10);
    rc(IDX_MONITOR, 8'h41);
    rc(IDX_STATUS, 8'h80);
    m_u.frame(8'hc3, 8, 1'b0, rx);
    w(10);
    chk(rx, 8'ha5);
    rc(IDX_STATUS, 8'h85);
    rc(IDX_DATA, 8'hc3);
    rc(IDX_STATUS, 8'h81);
  endtask
  // two frames with nothing to send and nothing read between them
  task automatic t_errors;
    m_u.frame(8'h11, 8, 1'b0, rx);
    m_u.frame(8'h22, 8, 1'b0, rx);
    w(10);
    chk(rx, 8'h00);
    rc(IDX_STATUS, 8'hcd);
    wr(IDX_STATUS, 8'h00);
    rc(IDX_STATUS, 8'hcd);
    wr(IDX_STATUS, 8'h48);
    rc(IDX_STATUS, 8'h85);
    rc(IDX_DATA, 8'h11);
  endtask
  task automatic t_length;
    wr(IDX_MODE, 8'h0c);
    wr(IDX_DATA, 8'h06);
    m_u.frame(8'h05, 3, 1'b0, rx);
    w(10);
    chk(rx, 8'h06);
    rc(IDX_DATA, 8'h05);
    wr(IDX_MODE, 8'h00);
    wr(IDX_DATA, 8'h00);
    m_u.frame(8'h05, 3, 1'b0, rx);
    w(10);
    rc(IDX_STATUS, 8'h91);
    wr(IDX_STATUS, 8'h10);
    rc(IDX_STATUS, 8'h81);
  endtask
  task automatic t_timeout;
    wr(IDX_CTRL, 8'h05);
    wr(IDX_DATA, 8'hff);
    m_u.frame(8'h80, 1, 1'b1, rx);
    w(40);
    rc(IDX_STATUS, 8'h90);
    m_u.sel(1'b1, 1'b0);
    w(10);
    rc(IDX_STATUS, 8'h91);
    wr(IDX_STATUS, 8'h10);
  endtask
  task automatic t_master;
    wr(IDX_CTRL, 8'h03);
    wr(IDX_IRQ_MASK, 8'h20);
    bus(1'b0, IDX_IRQ_STAT, 8'h00, rd);
    wr(IDX_DATA, 8'h5a);
    w(6);
    chk({7'h0, sck_oe}, 8'h01);
    rc(IDX_STATUS, 8'h83);
    w(40);
    rc(IDX_MONITOR, 8'h40);
    m_u.sel(1'b0, 1'b1);
    w(10);
    rc(IDX_STATUS, 8'ha4);
    chk({7'h0, irq}, 8'h01);
    m_u.sel(1'b1, 1'b0);
    w(10);
    bus(1'b0, IDX_IRQ_STAT, 8'h00, rd);
    chk(rd & 8'h20, 8'h20);
    w(2);
    chk({7'h0, irq}, 8'h00);
    wr(IDX_CTRL, 8'h00);
    rc(IDX_STATUS, 8'h81);
    rc(IDX_MONITOR, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    rst       = 1'b1;
    read      = 1'b0;
    write     = 1'b0;
    address   = '0;
    writedata = '0;
    err_count = 0;
    checks    = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_slave();
    t_errors();
    t_length();
    t_timeout();
    t_master();
    end_sim();
  end
endmodule
